// ===== verilog/link_err_pkg.sv
// constants and types for the link error recovery block
`default_nettype none
package link_err_pkg;
  localparam int          SEQ_W       = 3;
  localparam int          CNT_W       = 8;
  localparam int          CRD_W       = 2;
  localparam int          TMR_W       = 16;
  localparam int          CLK_MHZ     = 20;
  localparam int          PEND_HP_US  = 3;
  localparam int          CREDIT_HP_US = 5000;
  localparam int          PEND_HP_CYC = PEND_HP_US * CLK_MHZ;
  localparam int          CREDIT_HP_CYC = CREDIT_HP_US * CLK_MHZ;
  localparam logic [2:0]  NXT_NONE    = 3'h0;
  localparam logic [2:0]  NXT_RECOV   = 3'h1;
  localparam logic [2:0]  NXT_RXDET   = 3'h2;
  localparam logic [2:0]  NXT_SSDIS   = 3'h3;
  localparam logic [2:0]  NXT_SSINACT = 3'h4;
  typedef enum logic [1:0] {ADV_SEQ, ADV_CRD, ADV_RUN, ADV_IDLE} adv_e;
endpackage : link_err_pkg
`default_nettype wire

// ===== verilog/link_error_recovery.sv
// link error detection, recovery path choice and link error count
// Operation
// - non-advertising ack with wrong sequence number causes recovery
// - ack sequence number loads from the partner's advertisement
// - sequence advertisement comes first after every entry to U0
// - missing, late or preceded sequence advertisement causes recovery
// - credit advertisement follows the sequence advertisement
// - missing or preceded credit advertisement causes recovery
// - count rises by one per error driven entry to recovery
// - only a downstream port keeps the count
// - count clears on any reset and on entering polling idle
// - training substate timeouts are training sequence errors
// - polling training error goes to rx detect or disabled
// - recovery training error goes to inactive or rx detect
// - training errors leave the count alone
// - disparity outside plus two, zero, minus two is flagged
// - unknown ten-bit symbol is flagged as decode error
// - symbol errors may drop current packet, count unchanged
// - header crc errors use retry and leave count alone; here the count is left alone but send_lbad is not raised for them
// - rx header sequence mismatch causes recovery and counts
// - invalid link commands are ignored, count unchanged
// - missed ack or credit command causes recovery and counts
// - inactive state holds until software directs it out
// - unexpected commands and packets are ignored
// - credits out of order or credit timer expiry mean missing credit
`default_nettype none
module link_error_recovery #(
  parameter int PEND_CYC   = link_err_pkg::PEND_HP_CYC,
  parameter int CREDIT_CYC = link_err_pkg::CREDIT_HP_CYC
) (
  input  wire logic                            clk_sys,
  input  wire logic                            sys_rst,
  input  wire logic                            is_downstream,
  input  wire logic                            is_hub,
  input  wire logic                            u0_entry,
  input  wire logic                            polling_idle_entry,
  input  wire logic                            inband_reset_done,
  input  wire logic                            leave_inactive,
  input  wire logic                            hot_reset_attempt,
  input  wire logic                            adv_sent,
  input  wire logic                            credit_sent,
  input  wire logic                            tx_hp_sent,
  input  wire logic                            rx_lgood,
  input  wire logic [link_err_pkg::SEQ_W-1:0]  rx_lgood_seq,
  input  wire logic                            rx_lcrd,
  input  wire logic [link_err_pkg::CRD_W-1:0]  rx_lcrd_id,
  input  wire logic                            rx_lgo_ux,
  input  wire logic                            rx_hp,
  input  wire logic                            rx_hp_crc_bad,
  input  wire logic                            rx_hp_seq_bad,
  input  wire logic                            rx_lc_invalid,
  input  wire logic                            rx_lc_missed,
  input  wire logic                            in_hp,
  input  wire logic                            in_lc,
  input  wire logic                            in_dpp,
  input  wire logic                            ts_timeout_poll,
  input  wire logic                            ts_timeout_recov,
  input  wire logic signed [2:0]               rx_disparity,
  input  wire logic                            rx_sym_unknown,
  output logic                                 go_recovery,
  output logic [2:0]                           next_state,
  output logic                                 in_inactive,
  output logic                                 disparity_err,
  output logic                                 decode_err,
  output logic                                 send_lbad,
  output logic                                 drop_lc,
  output logic                                 drop_dpp,
  output logic [link_err_pkg::CNT_W-1:0]       link_err_cnt
);
  import link_err_pkg::*;

  localparam logic [TMR_W-1:0] PEND_T = TMR_W'(PEND_CYC);
  localparam logic [31:0] CRED_T = 32'(CREDIT_CYC);
  localparam logic [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};

  adv_e               adv_reg, adv_next;
  logic               seq_rx_reg, seq_rx_next;
  logic               crd_rx_reg, crd_rx_next;
  logic               own_adv_reg, own_adv_next;
  logic               own_crd_reg, own_crd_next;
  logic [SEQ_W-1:0]   ack_seq_reg, ack_seq_next;
  logic [CRD_W-1:0]   crd_last_reg, crd_last_next;
  logic [TMR_W-1:0]   pend_reg, pend_next;
  logic [31:0]        cred_reg, cred_next;
  logic               recov_reg, recov_next;
  logic [2:0]         nst_reg, nst_next;
  logic               inact_reg, inact_next;
  logic               disp_reg, disp_next;
  logic               dec_reg, dec_next;
  logic               lbad_reg, lbad_next;
  logic               dlc_reg, dlc_next;
  logic               ddpp_reg, ddpp_next;
  logic [CNT_W-1:0]   cnt_reg, cnt_next;
  logic               err_recov;

  function automatic logic disp_ok(input logic signed [2:0] d);
    disp_ok = (d == 3'sh2) || (d == 3'sh0) || (d == -3'sh2);
  endfunction : disp_ok

  always_comb begin
    adv_next      = adv_reg;
    seq_rx_next   = seq_rx_reg;
    crd_rx_next   = crd_rx_reg;
    // own advertisement and credits stay marked once sent
    own_adv_next  = own_adv_reg || adv_sent;
    own_crd_next  = own_crd_reg || credit_sent;
    ack_seq_next  = ack_seq_reg;
    crd_last_next = crd_last_reg;
    pend_next     = pend_reg;
    cred_next     = cred_reg;
    err_recov     = 1'b0;
    if (adv_reg == ADV_SEQ) begin
      // partner advertisement awaited; timer runs until it arrives
      if (!seq_rx_reg && pend_reg != '0)
        pend_next = pend_reg - TMR_W'(1);
      if (!seq_rx_reg && pend_reg == TMR_W'(1))
        err_recov = 1'b1;
      if (rx_hp && !own_adv_next)
        err_recov = 1'b1;
      if ((rx_lcrd || rx_lgo_ux) && !seq_rx_reg)
        err_recov = 1'b1;
      if (rx_lgood && !seq_rx_reg) begin
        seq_rx_next  = 1'b1;
        ack_seq_next = rx_lgood_seq;
      end
      if (own_adv_next && (seq_rx_reg || rx_lgood))
        adv_next = ADV_CRD;
    end else if (adv_reg == ADV_CRD) begin
      if (!crd_rx_reg && cred_reg != '0)
        cred_next = cred_reg - 32'h1;
      if (!crd_rx_reg && cred_reg == 32'h1)
        err_recov = 1'b1;
      if (rx_hp && !own_crd_next)
        err_recov = 1'b1;
      if (rx_lgo_ux && !crd_rx_reg && !rx_lcrd)
        err_recov = 1'b1;
      if (rx_lcrd) begin
        crd_rx_next   = 1'b1;
        crd_last_next = rx_lcrd_id;
      end
      if (own_crd_next && (crd_rx_reg || rx_lcrd))
        adv_next = ADV_RUN;
    end else if (adv_reg == ADV_RUN) begin
      if (tx_hp_sent || rx_lgood)
        pend_next = PEND_T;
      if (rx_lgood) begin
        // every ack, stray or not, is checked against the expected sequence number
        if (rx_lgood_seq != ack_seq_reg)
          err_recov = 1'b1;
        ack_seq_next = ack_seq_reg + SEQ_W'(1);
      end
      if (rx_lcrd) begin
        if (rx_lcrd_id != crd_last_reg + CRD_W'(1))
          err_recov = 1'b1;
        crd_last_next = rx_lcrd_id;
      end
    end
    if (rx_hp && !rx_hp_crc_bad && rx_hp_seq_bad && adv_reg == ADV_RUN)
      err_recov = 1'b1;
    if (rx_lc_missed)
      err_recov = 1'b1;
    // invalid commands change nothing here
    if (err_recov)
      adv_next = ADV_IDLE;
    if (u0_entry) begin
      adv_next    = ADV_SEQ;
      seq_rx_next = 1'b0;
      crd_rx_next = 1'b0;
      own_adv_next = 1'b0;
      own_crd_next = 1'b0;
      pend_next   = PEND_T;
      cred_next   = CRED_T;
    end
  end

  always_comb begin
    recov_next = err_recov;
    nst_next   = err_recov ? NXT_RECOV : NXT_NONE;
    inact_next = inact_reg && !leave_inactive;
    if (ts_timeout_poll) begin
      nst_next = (is_downstream || is_hub) ? NXT_RXDET : NXT_SSDIS;
    end else if (ts_timeout_recov) begin
      if (is_downstream && hot_reset_attempt)
        nst_next = NXT_RXDET;
      else begin
        nst_next   = NXT_SSINACT;
        inact_next = 1'b1;
      end
    end
    disp_next = !disp_ok(rx_disparity);
    dec_next  = rx_sym_unknown;
    lbad_next = (disp_next || dec_next) && in_hp;
    dlc_next  = (disp_next || dec_next) && in_lc;
    ddpp_next = (disp_next || dec_next) && in_dpp;
    cnt_next  = cnt_reg;
    // only error driven recovery counts
    if (err_recov && is_downstream && cnt_reg != CNT_MAX)
      cnt_next = cnt_reg + CNT_W'(1);
    if (polling_idle_entry || inband_reset_done)
      cnt_next = '0;
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      adv_reg      <= ADV_IDLE;
      seq_rx_reg   <= 1'b0;
      crd_rx_reg   <= 1'b0;
      own_adv_reg  <= 1'b0;
      own_crd_reg  <= 1'b0;
      ack_seq_reg  <= '0;
      crd_last_reg <= '0;
      pend_reg     <= '0;
      cred_reg     <= '0;
      recov_reg    <= 1'b0;
      nst_reg      <= NXT_NONE;
      inact_reg    <= 1'b0;
      disp_reg     <= 1'b0;
      dec_reg      <= 1'b0;
      lbad_reg     <= 1'b0;
      dlc_reg      <= 1'b0;
      ddpp_reg     <= 1'b0;
      cnt_reg      <= '0;
    end else begin
      adv_reg      <= adv_next;
      seq_rx_reg   <= seq_rx_next;
      crd_rx_reg   <= crd_rx_next;
      own_adv_reg  <= own_adv_next;
      own_crd_reg  <= own_crd_next;
      ack_seq_reg  <= ack_seq_next;
      crd_last_reg <= crd_last_next;
      pend_reg     <= pend_next;
      cred_reg     <= cred_next;
      recov_reg    <= recov_next;
      nst_reg      <= nst_next;
      inact_reg    <= inact_next;
      disp_reg     <= disp_next;
      dec_reg      <= dec_next;
      lbad_reg     <= lbad_next;
      dlc_reg      <= dlc_next;
      ddpp_reg     <= ddpp_next;
      cnt_reg      <= cnt_next;
    end
  end

  assign go_recovery   = recov_reg;
  assign next_state    = nst_reg;
  assign in_inactive   = inact_reg;
  assign disparity_err = disp_reg;
  assign decode_err    = dec_reg;
  assign send_lbad     = lbad_reg;
  assign drop_lc       = dlc_reg;
  assign drop_dpp      = ddpp_reg;
  assign link_err_cnt  = cnt_reg;

  property p_ack_mismatch;
    @(posedge clk_sys) disable iff (sys_rst)
      (adv_reg == ADV_RUN && rx_lgood && rx_lgood_seq != ack_seq_reg
       && !u0_entry) |=> go_recovery;
  endproperty
  a_ack_mismatch: assert property (p_ack_mismatch)
    else $error("ack mismatch did not start recovery");

  property p_adv_load;
    @(posedge clk_sys) disable iff (sys_rst)
      (adv_reg == ADV_SEQ && rx_lgood && !seq_rx_reg && !u0_entry)
      |=> ack_seq_reg == $past(rx_lgood_seq);
  endproperty
  a_adv_load: assert property (p_adv_load)
    else $error("ack sequence not loaded from advertisement");

  property p_adv_early;
    @(posedge clk_sys) disable iff (sys_rst)
      (adv_reg == ADV_SEQ && !seq_rx_reg && rx_lgo_ux && !u0_entry)
      |=> go_recovery && next_state == NXT_RECOV;
  endproperty
  a_adv_early: assert property (p_adv_early)
    else $error("early power command not flagged");

  property p_crd_hp;
    @(posedge clk_sys) disable iff (sys_rst)
      (adv_reg == ADV_CRD && rx_hp && !credit_sent && !own_crd_reg)
      |=> go_recovery;
  endproperty
  a_crd_hp: assert property (p_crd_hp)
    else $error("packet before credits not flagged");

  property p_cnt_inc;
    @(posedge clk_sys) disable iff (sys_rst)
      (go_recovery && $past(is_downstream) && !$past(polling_idle_entry)
       && !$past(inband_reset_done) && $past(cnt_reg) != CNT_MAX)
      |-> link_err_cnt == $past(link_err_cnt) + CNT_W'(1);
  endproperty
  a_cnt_inc: assert property (p_cnt_inc)
    else $error("count did not rise with recovery");

  property p_upstream_hold;
    @(posedge clk_sys) disable iff (sys_rst)
      (!is_downstream && !polling_idle_entry && !inband_reset_done)
      |=> $stable(link_err_cnt);
  endproperty
  a_upstream_hold: assert property (p_upstream_hold)
    else $error("upstream port changed count");

  property p_cnt_clr;
    @(posedge clk_sys) disable iff (sys_rst)
      (polling_idle_entry || inband_reset_done) |=> link_err_cnt == '0;
  endproperty
  a_cnt_clr: assert property (p_cnt_clr)
    else $error("count not cleared");

  property p_poll_ts;
    @(posedge clk_sys) disable iff (sys_rst)
      (ts_timeout_poll && !is_downstream && !is_hub)
      |=> next_state == NXT_SSDIS;
  endproperty
  a_poll_ts: assert property (p_poll_ts)
    else $error("peripheral polling timeout path wrong");

  property p_recov_ts;
    @(posedge clk_sys) disable iff (sys_rst)
      (ts_timeout_recov && !ts_timeout_poll && !hot_reset_attempt)
      |=> next_state == NXT_SSINACT && in_inactive;
  endproperty
  a_recov_ts: assert property (p_recov_ts)
    else $error("recovery timeout path wrong");

  property p_disp;
    @(posedge clk_sys) disable iff (sys_rst)
      (rx_disparity == 3'sh1) |=> disparity_err;
  endproperty
  a_disp: assert property (p_disp)
    else $error("disparity error missed");

  property p_sat;
    @(posedge clk_sys) disable iff (sys_rst)
      (link_err_cnt == CNT_MAX && !polling_idle_entry && !inband_reset_done)
      |=> link_err_cnt == CNT_MAX;
  endproperty
  a_sat: assert property (p_sat)
    else $error("count wrapped");

  c_recov: cover property (@(posedge clk_sys) go_recovery);
  c_run: cover property (@(posedge clk_sys) adv_reg == ADV_RUN);
  c_inact: cover property (@(posedge clk_sys) in_inactive);
  c_lbad: cover property (@(posedge clk_sys) send_lbad);
endmodule : link_error_recovery
`default_nettype wire

// ===== sim/link_partner.sv
// behavioural partner port: advertises sequence and credits, then acks
`default_nettype none
module link_partner (
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  input  wire logic       start,
  input  wire logic       ack,
  input  wire logic       bad_ack,
  input  wire logic       slow,
  input  wire logic       hold_crd,
  input  wire logic [2:0] adv_seq,
  output logic            lgood,
  output logic [2:0]      lgood_seq,
  output logic            lcrd,
  output logic [1:0]      lcrd_id,
  output logic            busy
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] ph;
  logic [2:0] nxt;
  logic       gap;
  always @(posedge clk_sys) begin
    lgood <= 1'b0;
    lcrd  <= 1'b0;
    {lgood_seq, lcrd_id} <= ~{lgood_seq, lcrd_id};
    gap   <= slow & ~gap;
    if (sys_rst) begin
      busy <= 1'b0;
      {lgood_seq, lcrd_id} <= 5'h0;
    end else if (start) begin
      busy <= 1'b1;
      ph   <= 3'h0;
    end else if (busy && !gap) begin
      if (ph == 3'h0) begin
        lgood     <= 1'b1;
        lgood_seq <= adv_seq;
        nxt       <= adv_seq;
        busy      <= ~hold_crd;
      end else begin
        lcrd    <= 1'b1;
        lcrd_id <= ph[1:0] - 2'h1;
        busy    <= (ph != 3'h4);
      end
      ph <= ph + 3'h1;
    end else if (ack && !busy) begin
      lgood     <= 1'b1;
      lgood_seq <= bad_ack ? nxt + 3'h2 : nxt;
      nxt       <= nxt + 3'h1;
    end
  end
endmodule : link_partner
`default_nettype wire

// ===== sim/link_error_recovery_tb.sv
// self-checking bench for the link error recovery block
`default_nettype none
module link_error_recovery_tb;
  import link_err_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [14:0] U0 = 15'h1, ADV = 15'h2, CRS = 15'h4,
    LGO = 15'h8, HP = 15'h10, MISS = 15'h20, TPOL = 15'h40, TREC = 15'h80,
    PIDL = 15'h100, IBR = 15'h200, LEAVE = 15'h400, INV = 15'h800,
    SYM = 15'h1000, PST = 15'h2000, PACK = 15'h4000;
  logic clk_sys = 1'b0, sys_rst = 1'b1, ds = 1'b1, hub = 1'b0, hot = 1'b0;
  logic crc_bad = 1'b0, seq_bad = 1'b0, p_bad = 1'b0, p_slow = 1'b0;
  logic p_hold = 1'b0, p_busy, lgood, lcrd, go_recovery, in_inactive;
  logic disparity_err, decode_err, send_lbad, drop_lc, drop_dpp;
  logic [14:0] pv = 15'h0;
  logic [2:0] inx = 3'h0, p_seq = 3'h0, lg_seq, next_state;
  logic [1:0] crd_id;
  logic signed [2:0] disp = 3'sh0;
  logic [7:0] link_err_cnt;
  int n_mismatch = 0, comparisons = 0, cycles = 0, exp_cnt = 0;
  link_error_recovery #(.PEND_CYC(20), .CREDIT_CYC(20)) uut (
    .clk_sys, .sys_rst, .is_downstream(ds), .is_hub(hub),
    .u0_entry(pv[0]), .polling_idle_entry(pv[8]),
    .inband_reset_done(pv[9]), .leave_inactive(pv[10]),
    .hot_reset_attempt(hot), .adv_sent(pv[1]), .credit_sent(pv[2]),
    .tx_hp_sent(1'b0), .rx_lgood(lgood), .rx_lgood_seq(lg_seq),
    .rx_lcrd(lcrd), .rx_lcrd_id(crd_id), .rx_lgo_ux(pv[3]),
    .rx_hp(pv[4]), .rx_hp_crc_bad(crc_bad), .rx_hp_seq_bad(seq_bad),
    .rx_lc_invalid(pv[11]), .rx_lc_missed(pv[5]), .in_hp(inx[0]),
    .in_lc(inx[1]), .in_dpp(inx[2]), .ts_timeout_poll(pv[6]),
    .ts_timeout_recov(pv[7]), .rx_disparity(disp),
    .rx_sym_unknown(pv[12]), .go_recovery, .next_state, .in_inactive,
    .disparity_err, .decode_err, .send_lbad, .drop_lc, .drop_dpp,
    .link_err_cnt);
  link_partner partner (.clk_sys, .sys_rst, .start(pv[13]), .ack(pv[14]),
    .bad_ack(p_bad), .slow(p_slow), .hold_crd(p_hold), .adv_seq(p_seq),
    .lgood, .lgood_seq(lg_seq), .lcrd, .lcrd_id(crd_id), .busy(p_busy));
  initial forever #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 6000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk1(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: flag %b not %b", $time, got, exp);
    end
  endtask : chk1
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %h not %h", $time, got, exp);
    end
  endtask : chk8
  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : idle
  task automatic pulse(input logic [14:0] m);
    @(posedge clk_sys);
    pv <= m;
    @(posedge clk_sys);
    pv <= 15'h0;
    #1;
  endtask : pulse
  task automatic quiet();
    repeat (3) begin
      chk8({5'h0, next_state}, 8'h00);
      idle(1);
    end
  endtask : quiet
  task automatic wait_ev(input logic [2:0] st);
    int i;
    for (i = 0; i < 40 && next_state === 3'h0; i++) idle(1);
    chk8({5'h0, next_state}, {5'h0, st});
    chk1(go_recovery, st == NXT_RECOV);
    chk8(link_err_cnt, exp_cnt[7:0]);
  endtask : wait_ev
  task automatic bring_up(input logic [2:0] s, input logic slow);
    int i;
    p_seq  = s;
    p_slow = slow;
    pulse(U0);
    pulse(ADV);
    pulse(PST);
    for (i = 0; i < 40 && p_busy === 1'b1; i++) idle(1);
    if (!p_hold) pulse(CRS);
    p_slow = 1'b0;
  endtask : bring_up
  task automatic t_roles();
    logic [2:0] ex [6];
    int i;
    ex = '{NXT_RXDET, NXT_RXDET, NXT_SSDIS, NXT_SSINACT, NXT_SSINACT,
           NXT_RXDET};
    @(posedge clk_sys);
    ds <= 1'b0;
    pulse(MISS);
    wait_ev(NXT_RECOV);
    for (i = 0; i < 6; i++) begin
      @(posedge clk_sys);
      ds  <= (i == 0) || (i >= 4);
      hub <= (i == 1);
      hot <= (i == 5);
      pulse(i < 3 ? TPOL : TREC);
      wait_ev(ex[i]);
      idle(5);
      chk1(in_inactive, ex[i] == NXT_SSINACT);
      pulse(LEAVE);
      chk1(in_inactive, 1'b0);
    end
    @(posedge clk_sys);
    {ds, hub, hot} <= 3'h4;
    $display("test roles done");
  endtask : t_roles
  task automatic t_symbol();
    int d;
    for (d = -4; d < 4; d++) begin
      @(posedge clk_sys);
      disp <= d[2:0];
      idle(1);
      chk1(disparity_err, !(d == -2 || d == 0 || d == 2));
    end
    for (d = 0; d < 3; d++) begin
      @(posedge clk_sys);
      disp <= 3'sh0;
      inx  <= 3'h1 << d;
      pulse(SYM);
      chk1(decode_err, 1'b1);
      chk8({5'h0, drop_dpp, drop_lc, send_lbad}, {5'h0, inx});
      chk8(link_err_cnt, exp_cnt[7:0]);
    end
    @(posedge clk_sys);
    inx <= 3'h0;
    $display("test symbol done");
  endtask : t_symbol
  task automatic t_ack();
    int k;
    for (k = 0; k < 2; k++) begin
      bring_up(k ? 3'h7 : 3'h5, k == 0);
      pulse(PACK);
      quiet();
      pulse(PACK);
      quiet();
      p_bad = 1'b1;
      pulse(PACK);
      exp_cnt++;
      wait_ev(NXT_RECOV);
      p_bad = 1'b0;
    end
    $display("test ack done");
  endtask : t_ack
  task automatic t_adv();
    logic [14:0] pre [3];
    logic [14:0] m [3];
    int k;
    pre = '{15'h0, 15'h0, ADV};
    m   = '{LGO, HP, 15'h0};
    for (k = 0; k < 3; k++) begin
      pulse(U0);
      if (pre[k] != 15'h0) pulse(pre[k]);
      if (m[k] != 15'h0) pulse(m[k]);
      exp_cnt++;
      wait_ev(NXT_RECOV);
    end
    p_hold = 1'b1;
    for (k = 0; k < 3; k++) begin
      bring_up(3'h2, 1'b0);
      if (m[k] != 15'h0) pulse(m[k]);
      exp_cnt++;
      wait_ev(NXT_RECOV);
    end
    p_hold = 1'b0;
    $display("test advertisement done");
  endtask : t_adv
  task automatic t_misc();
    bring_up(3'h0, 1'b0);
    @(posedge clk_sys);
    crc_bad <= 1'b1;
    pulse(HP);
    quiet();
    @(posedge clk_sys);
    crc_bad <= 1'b0;
    pulse(INV);
    quiet();
    @(posedge clk_sys);
    seq_bad <= 1'b1;
    pulse(HP);
    exp_cnt++;
    wait_ev(NXT_RECOV);
    @(posedge clk_sys);
    seq_bad <= 1'b0;
    pulse(LGO);
    quiet();
    $display("test misc done");
  endtask : t_misc
  task automatic t_count();
    repeat (260) pulse(MISS);
    idle(10);
    chk8(link_err_cnt, 8'hff);
    pulse(PIDL);
    chk8(link_err_cnt, 8'h00);
    exp_cnt = 1;
    pulse(MISS);
    wait_ev(NXT_RECOV);
    pulse(IBR);
    chk8(link_err_cnt, 8'h00);
    pulse(MISS);
    @(posedge clk_sys);
    sys_rst <= 1'b1;
    @(posedge clk_sys);
    sys_rst <= 1'b0;
    #1;
    chk8(link_err_cnt, 8'h00);
    $display("test count done");
  endtask : t_count
  initial begin
    repeat (4) @(posedge clk_sys);
    sys_rst <= 1'b0;
    idle(1);
    chk8(link_err_cnt, 8'h00);
    t_roles();
    t_symbol();
    t_ack();
    t_adv();
    t_misc();
    t_count();
    report_and_stop();
  end
endmodule : link_error_recovery_tb
`default_nettype wire
